// ===== rtl/parallel_port_defs.svh
`ifndef PARALLEL_PORT_DEFS_SVH
`define PARALLEL_PORT_DEFS_SVH

// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define IDX_PORT_A_DATA 6'h00
`define IDX_PORT_B_DATA 6'h01
`define IDX_PORT_C_DATA 6'h02
`define IDX_PORT_D_DATA 6'h03
`define IDX_PORT_A_DIRECTION 6'h04
`define IDX_PORT_B_DIRECTION 6'h05
`define IDX_PORT_C_DIRECTION 6'h06
`define IDX_PORT_D_DIRECTION 6'h07
`define IDX_PORT_E_DATA 6'h08
`define IDX_PORT_E_DIRECTION 6'h0C
`define IDX_PORT_A_PULLUP_ENABLE 6'h0D
`define IDX_PORT_C_PULLUP_ENABLE 6'h0E
`define IDX_PORT_D_PULLUP_ENABLE 6'h0F
`define IDX_KEYPAD_IRQ_ENABLES 6'h10
`define IDX_PERIPH_ENABLES 6'h11
`define IDX_CONVERTER_CHANNEL 6'h12
`define IDX_TIMER_EDGE_SELECT 6'h13

// ------------------------------------------------------------
// Implemented bit masks
// ------------------------------------------------------------
`define MASK_PORT_A 8'hFF
`define MASK_PORT_B 8'hFF
`define MASK_PORT_C 8'h7F
`define MASK_PORT_D 8'hFF
`define MASK_PORT_E 8'h1F
`define MASK_PUE_A 8'hFF
`define MASK_PUE_B 8'h00
`define MASK_PUE_C 8'h7F
`define MASK_PUE_D 8'hFF
`define MASK_PUE_E 8'h00
`define MASK_CHANNEL 8'h1F

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RST_DIRECTION 8'h00
`define RST_PULLUP 8'h00
`define RST_KEYPAD 8'h00
`define RST_PERIPH 8'h00
`define RST_CHANNEL 5'h1F
`define RST_TIMER 8'h00

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define BIT_SERIAL_PERIPH_ENABLE 0
`define BIT_ASYNC_SERIAL_ENABLE 1
`define BIT_EXT_CLOCK_GEN_ON 2
`define BIT_CRYSTAL_DRIVE_ENABLE 3
`define FLD_T1_CH0 1:0
`define FLD_T1_CH1 3:2
`define FLD_T2_CH0 5:4
`define FLD_T2_CH1 7:6

`endif

// ===== rtl/parallel_port_pkg.sv
package parallel_port_pkg;

	// Port numbering on the flat pin buses
	typedef enum {PORT_A, PORT_B, PORT_C, PORT_D, PORT_E} port_e;

	typedef logic [7:0] byte_t;
	typedef logic [39:0] pins_t;

endpackage : parallel_port_pkg

// ===== rtl/pin_sync_if.sv
`timescale 1ns/1ps
interface pin_sync_if;
	parallel_port_pkg::pins_t raw;
	parallel_port_pkg::pins_t synced;

	modport sync_side (input raw, output synced);
	modport user_side (output raw, input synced);
endinterface : pin_sync_if

// ===== rtl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Pin levels
	pin_sync_if.sync_side pins
);

	parallel_port_pkg::pins_t stage1_r;
	parallel_port_pkg::pins_t stage2_r;

	// ------------------------------------------------------------
	// Two-stage synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stage1_r <= 40'h00_0000_0000;
			stage2_r <= 40'h00_0000_0000;
		end else begin
			stage1_r <= pins.raw;
			stage2_r <= stage1_r;
		end
	end

	assign pins.synced = stage2_r;

endmodule : pin_sync

// ===== rtl/parallel_port_control.sv
`timescale 1ns/1ps
`include "parallel_port_defs.svh"

module parallel_port_control (
	// Clock and reset
	input wire logic SYS_CLK_I,
	input wire logic RSTN_I,
	// Wishbone slave
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	// Pins, eight per port, port A lowest
	input wire logic [39:0] PIN_IN_I,
	output logic [39:0] PIN_OUT_O,
	output logic [39:0] PIN_OE_O,
	output logic [39:0] PIN_PULLUP_O,
	output logic [39:0] PIN_CLAIM_O,
	// Keypad interrupt unit
	output logic [7:0] KEYPAD_INPUTS_O
);

	// ------------------------------------------------------------
	// Per-port constants
	// ------------------------------------------------------------
	localparam int NPORT = 5;
	localparam logic [5:0] DATA_IDX [0:NPORT-1] = '{
		`IDX_PORT_A_DATA, `IDX_PORT_B_DATA, `IDX_PORT_C_DATA,
		`IDX_PORT_D_DATA, `IDX_PORT_E_DATA};
	localparam logic [5:0] DIR_IDX [0:NPORT-1] = '{
		`IDX_PORT_A_DIRECTION, `IDX_PORT_B_DIRECTION, `IDX_PORT_C_DIRECTION,
		`IDX_PORT_D_DIRECTION, `IDX_PORT_E_DIRECTION};
	localparam logic [5:0] PUE_IDX [0:NPORT-1] = '{
		`IDX_PORT_A_PULLUP_ENABLE, 6'h3F, `IDX_PORT_C_PULLUP_ENABLE,
		`IDX_PORT_D_PULLUP_ENABLE, 6'h3F};
	localparam logic [7:0] PIN_MASK [0:NPORT-1] = '{
		`MASK_PORT_A, `MASK_PORT_B, `MASK_PORT_C, `MASK_PORT_D, `MASK_PORT_E};
	localparam logic [7:0] PUE_MASK [0:NPORT-1] = '{
		`MASK_PUE_A, `MASK_PUE_B, `MASK_PUE_C, `MASK_PUE_D, `MASK_PUE_E};

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic ack_r;
	logic req;
	logic wr;
	logic [5:0] idx;

	assign req = WB_CYC_I & WB_STB_I & ~ack_r;
	assign wr = req & WB_WE_I & WB_SEL_I[0];
	assign idx = WB_ADR_I[7:2];

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	parallel_port_pkg::byte_t data_r [0:NPORT-1];
	parallel_port_pkg::byte_t dir_r [0:NPORT-1];
	parallel_port_pkg::byte_t pue_r [0:NPORT-1];
	parallel_port_pkg::byte_t view [0:NPORT-1];
	parallel_port_pkg::byte_t keypad_en_r;
	parallel_port_pkg::byte_t periph_r;
	parallel_port_pkg::byte_t timer_r;
	logic [4:0] channel_r;
	parallel_port_pkg::pins_t sync_in;
	parallel_port_pkg::pins_t dir_flat;
	parallel_port_pkg::pins_t data_flat;
	parallel_port_pkg::pins_t pue_flat;
	parallel_port_pkg::pins_t claim_nxt;
	parallel_port_pkg::byte_t rd_nxt;
	logic [NPORT-1:0] data_we;
	logic [NPORT-1:0] dir_we;
	logic [NPORT-1:0] pue_we;

	// ------------------------------------------------------------
	// Input synchroniser
	// ------------------------------------------------------------
	pin_sync_if sync_bus ();

	assign sync_bus.raw = PIN_IN_I;
	assign sync_in = sync_bus.synced;

	pin_sync u_pin_sync (
		.clk_i(SYS_CLK_I),
		.rst_n_i(RSTN_I),
		.pins(sync_bus.sync_side)
	);

	// ------------------------------------------------------------
	// Per-port data, direction and pullup registers
	// ------------------------------------------------------------
	genvar p;
	generate
		for (p = 0; p < NPORT; p++) begin : g_port
			// Write strobes for this port's registers
			assign data_we[p] = wr && idx == DATA_IDX[p];
			assign dir_we[p] = wr && idx == DIR_IDX[p];
			assign pue_we[p] = wr && PUE_MASK[p] != 8'h00 && idx == PUE_IDX[p];

			// Data latch has no reset: content survives reset
			always_ff @(posedge SYS_CLK_I) begin
				if (data_we[p]) begin
					data_r[p] <= WB_DAT_I[7:0] & PIN_MASK[p];
				end
			end

			always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
				if (!RSTN_I) begin
					dir_r[p] <= `RST_DIRECTION;
				end else if (dir_we[p]) begin
					dir_r[p] <= WB_DAT_I[7:0] & PIN_MASK[p];
				end
			end

			always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
				if (!RSTN_I) begin
					pue_r[p] <= `RST_PULLUP;
				end else if (pue_we[p]) begin
					pue_r[p] <= WB_DAT_I[7:0] & PUE_MASK[p];
				end
			end

			// Latch for outputs, synchronised pin for inputs
			assign view[p] = ((dir_r[p] & data_r[p]) |
				(~dir_r[p] & sync_in[p*8 +: 8])) & PIN_MASK[p];

			assign dir_flat[p*8 +: 8] = dir_r[p];
			assign data_flat[p*8 +: 8] = data_r[p] & PIN_MASK[p];
			assign pue_flat[p*8 +: 8] = pue_r[p];
		end
	endgenerate

	// ------------------------------------------------------------
	// Peripheral control registers
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			keypad_en_r <= `RST_KEYPAD;
		end else if (wr && idx == `IDX_KEYPAD_IRQ_ENABLES) begin
			keypad_en_r <= WB_DAT_I[7:0];
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			periph_r <= `RST_PERIPH;
		end else if (wr && idx == `IDX_PERIPH_ENABLES) begin
			periph_r <= WB_DAT_I[7:0] & 8'h0F;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			channel_r <= `RST_CHANNEL;
		end else if (wr && idx == `IDX_CONVERTER_CHANNEL) begin
			channel_r <= WB_DAT_I[4:0];
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			timer_r <= `RST_TIMER;
		end else if (wr && idx == `IDX_TIMER_EDGE_SELECT) begin
			timer_r <= WB_DAT_I[7:0];
		end
	end

	// ------------------------------------------------------------
	// Pin ownership by peripherals
	// ------------------------------------------------------------
	always_comb begin
		claim_nxt = 40'h00_0000_0000;
		// Keypad enables take port A pins as interrupt inputs
		claim_nxt[7:0] = keypad_en_r;
		// Converter channel below eight takes one port B pin
		if (channel_r[4:3] == 2'h0) begin
			claim_nxt[8 + channel_r[2:0]] = 1'b1;
		end
		// Serial peripheral takes port D pins 0..3
		claim_nxt[27:24] = {4{periph_r[`BIT_SERIAL_PERIPH_ENABLE]}};
		// Timer channels take port D pins 4..7 when an edge is selected
		claim_nxt[28] = |timer_r[`FLD_T1_CH0];
		claim_nxt[29] = |timer_r[`FLD_T1_CH1];
		claim_nxt[30] = |timer_r[`FLD_T2_CH0];
		claim_nxt[31] = |timer_r[`FLD_T2_CH1];
		// Async serial takes port E pins 0 and 1
		claim_nxt[33:32] = {2{periph_r[`BIT_ASYNC_SERIAL_ENABLE]}};
		// Clock generator takes port E pins 3 and 4
		claim_nxt[35] = periph_r[`BIT_EXT_CLOCK_GEN_ON] |
			periph_r[`BIT_CRYSTAL_DRIVE_ENABLE];
		claim_nxt[36] = periph_r[`BIT_EXT_CLOCK_GEN_ON];
	end

	// ------------------------------------------------------------
	// Pin drivers, registered
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			PIN_OE_O <= 40'h00_0000_0000;
		end else begin
			PIN_OE_O <= dir_flat & ~claim_nxt;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			PIN_OUT_O <= 40'h00_0000_0000;
		end else begin
			PIN_OUT_O <= data_flat;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			PIN_PULLUP_O <= 40'h00_0000_0000;
		end else begin
			PIN_PULLUP_O <= pue_flat & ~dir_flat;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			PIN_CLAIM_O <= 40'h00_0000_0000;
		end else begin
			PIN_CLAIM_O <= claim_nxt;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			KEYPAD_INPUTS_O <= 8'h00;
		end else begin
			KEYPAD_INPUTS_O <= sync_in[7:0] & keypad_en_r;
		end
	end

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	always_comb begin
		rd_nxt = 8'h00;
		case (idx)
			`IDX_PORT_A_DATA: begin
				rd_nxt = view[0];
			end
			`IDX_PORT_B_DATA: begin
				rd_nxt = view[1];
			end
			`IDX_PORT_C_DATA: begin
				rd_nxt = view[2];
			end
			`IDX_PORT_D_DATA: begin
				rd_nxt = view[3];
			end
			`IDX_PORT_E_DATA: begin
				rd_nxt = view[4];
			end
			`IDX_PORT_A_DIRECTION: begin
				rd_nxt = dir_r[0];
			end
			`IDX_PORT_B_DIRECTION: begin
				rd_nxt = dir_r[1];
			end
			`IDX_PORT_C_DIRECTION: begin
				rd_nxt = dir_r[2];
			end
			`IDX_PORT_D_DIRECTION: begin
				rd_nxt = dir_r[3];
			end
			`IDX_PORT_E_DIRECTION: begin
				rd_nxt = dir_r[4];
			end
			`IDX_PORT_A_PULLUP_ENABLE: begin
				rd_nxt = pue_r[0];
			end
			`IDX_PORT_C_PULLUP_ENABLE: begin
				rd_nxt = pue_r[2];
			end
			`IDX_PORT_D_PULLUP_ENABLE: begin
				rd_nxt = pue_r[3];
			end
			`IDX_KEYPAD_IRQ_ENABLES: begin
				rd_nxt = keypad_en_r;
			end
			`IDX_PERIPH_ENABLES: begin
				rd_nxt = periph_r;
			end
			`IDX_CONVERTER_CHANNEL: begin
				rd_nxt = {3'h0, channel_r};
			end
			`IDX_TIMER_EDGE_SELECT: begin
				rd_nxt = timer_r;
			end
			// Unmapped index reads zero, still answered
			default: begin
				rd_nxt = 8'h00;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Bus answer
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			WB_DAT_O <= 32'h0000_0000;
		end else if (req) begin
			WB_DAT_O <= {24'h00_0000, rd_nxt};
		end
	end

	assign WB_ACK_O = ack_r;

endmodule : parallel_port_control

// ===== dv/parallel_port_control_assertions.sv
`timescale 1ns/1ps
// ----
// Port block checker
// ----
module parallel_port_control_checker (
	// Clock and reset
	input wire logic SYS_CLK_I,
	input wire logic RSTN_I,
	// Bus
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic WB_ACK_O,
	// Pins
	input wire logic [39:0] PIN_IN_I,
	input wire logic [39:0] PIN_OUT_O,
	input wire logic [39:0] PIN_OE_O,
	input wire logic [39:0] PIN_PULLUP_O,
	input wire logic [39:0] PIN_CLAIM_O,
	input wire logic [7:0] KEYPAD_INPUTS_O
);
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RSTN_I);
	logic req;
	logic wr;
	assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	assign wr = req && WB_WE_I && WB_SEL_I[0];
	a_ack_next: assert property (req |=> WB_ACK_O)
		else $error("no ack after request");
	a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
	a_read_upper: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h000000)
		else $error("upper read data not zero");
	a_pullup_out: assert property ((PIN_PULLUP_O & PIN_OE_O) == 40'h0000000000)
		else $error("pullup on a driven pin");
	a_claim_oe: assert property ((PIN_CLAIM_O & PIN_OE_O) == 40'h0000000000)
		else $error("claimed pin driven");
	a_no_pins: assert property (PIN_OE_O[39:37] == 3'h0 && !PIN_OE_O[23] && !PIN_PULLUP_O[23]
		&& PIN_PULLUP_O[39:32] == 8'h00 && PIN_PULLUP_O[15:8] == 8'h00)
		else $error("missing pin active");
	a_keypad_claim: assert property ((KEYPAD_INPUTS_O & ~(PIN_CLAIM_O[7:0]
		| $past(PIN_CLAIM_O[7:0]))) == 8'h00)
		else $error("keypad input on unclaimed pin");
	a_dir_to_oe: assert property (wr && WB_ADR_I[7:2] == 6'h04 |-> ##2
		PIN_OE_O[7:0] == ($past(WB_DAT_I[7:0], 2) & ~PIN_CLAIM_O[7:0]))
		else $error("direction write not on enables");
	a_pue_to_pin: assert property (wr && WB_ADR_I[7:2] == 6'h0D |-> ##2
		(PIN_PULLUP_O[7:0] & ~$past(WB_DAT_I[7:0], 2)) == 8'h00)
		else $error("pullup without enable bit");
	c_write: cover property (wr);
	c_read: cover property (req && !WB_WE_I);
	c_keypad: cover property (KEYPAD_INPUTS_O != 8'h00);
endmodule : parallel_port_control_checker

// ===== dv/board_model.sv
`timescale 1ns/1ps
// ----
// Board circuitry on the pins
// ----
module board_model (
	// Clock
	input wire logic clk_i,
	// Device side
	input wire logic [39:0] out_i,
	input wire logic [39:0] oe_i,
	input wire logic [39:0] pu_i,
	// Board drive
	input wire logic [39:0] lvl_i,
	input wire logic [39:0] en_i,
	output logic [39:0] pin_o
);
	logic [39:0] float_r = 40'h0000000000;
	always_ff @(posedge clk_i) begin
		for (int i = 0; i < 40; i++) begin
			// Released pin swings away from its last level, never stays unknown
			float_r[i] <= (pin_o[i] === 1'b1) ? 1'b0 : 1'b1;
		end
	end
	always_comb begin
		pin_o = (oe_i & out_i) | (~oe_i & en_i & lvl_i) | (~oe_i & ~en_i & (pu_i | float_r));
	end
endmodule : board_model

// ===== dv/tb.sv
`timescale 1ns/1ps
// ----
// Port block bench
// ----
module tb;
	logic SYS_CLK_I = 1'b0;
	logic RSTN_I = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h00000000;
	logic [3:0] sel = 4'h0;
	logic [39:0] lvl = 40'h0000000000;
	logic [39:0] en = 40'h0000000000;
	logic [39:0] pin_in, pout, poe, ppu, pclaim;
	logic [31:0] rdat;
	logic ack;
	logic [7:0] kp;
	logic [7:0] q;
	int err_count = 0;
	int tests_run = 0;
	logic [21:0] rows [8] = '{{6'h04, 8'h3C, 8'h3C}, {6'h06, 8'hFF, 8'h7F},
		{6'h07, 8'hFF, 8'hFF}, {6'h0C, 8'hFF, 8'h1F}, {6'h0D, 8'hA5, 8'hA5},
		{6'h0E, 8'hFF, 8'h7F}, {6'h0F, 8'h5A, 8'h5A}, {6'h3F, 8'hFF, 8'h00}};

	parallel_port_control DUT (.SYS_CLK_I(SYS_CLK_I), .RSTN_I(RSTN_I), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
		.WB_DAT_O(rdat), .WB_ACK_O(ack), .PIN_IN_I(pin_in), .PIN_OUT_O(pout),
		.PIN_OE_O(poe), .PIN_PULLUP_O(ppu), .PIN_CLAIM_O(pclaim), .KEYPAD_INPUTS_O(kp));
	board_model board (.clk_i(SYS_CLK_I), .out_i(pout), .oe_i(poe), .pu_i(ppu),
		.lvl_i(lvl), .en_i(en), .pin_o(pin_in));

	always #5 SYS_CLK_I = ~SYS_CLK_I;

	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic stop_test();
		$display("counts: %0d checks, %0d wrong", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : stop_test

	task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] d,
		input logic [3:0] s = 4'h1);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= s;
		adr <= {idx, 2'b00};
		dat <= {24'h000000, d};
		do begin
			@(posedge SYS_CLK_I);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) begin
			err_count++;
			$display("wrong value at %0t: no bus answer", $time);
		end
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge SYS_CLK_I);
	endtask : wb

	initial begin
		repeat (2000) @(posedge SYS_CLK_I);
		err_count++;
		stop_test();
	end

	initial begin
		repeat (6) @(posedge SYS_CLK_I);
		RSTN_I <= 1'b1;
		@(posedge SYS_CLK_I);
		foreach (rows[i]) begin
			wb(1'b0, rows[i][21:16], 8'h00);
			chk(q, 8'h00);
			wb(1'b1, rows[i][21:16], rows[i][15:8]);
			wb(1'b0, rows[i][21:16], 8'h00);
			chk(q, rows[i][7:0]);
		end
		$display("test registers done");
		wb(1'b1, 6'h04, 8'hF0);
		wb(1'b1, 6'h00, 8'h3C);
		en <= 40'h00000000FF;
		lvl <= 40'h000000000A;
		repeat (3) @(posedge SYS_CLK_I);
		wb(1'b0, 6'h00, 8'h00);
		chk(q, 8'h3A);
		chk(pout[7:0], 8'h3C);
		chk(poe[7:0], 8'hF0);
		chk(ppu[7:0], 8'h05);
		wb(1'b1, 6'h04, 8'h00);
		chk(ppu[7:0], 8'hA5);
		wb(1'b1, 6'h08, 8'hFF);
		wb(1'b0, 6'h08, 8'h00);
		chk(q, 8'h1F);
		$display("test data done");
		RSTN_I <= 1'b0;
		repeat (2) @(posedge SYS_CLK_I);
		RSTN_I <= 1'b1;
		repeat (2) @(posedge SYS_CLK_I);
		chk(pout[7:0], 8'h3C);
		chk(pout[39:32], 8'h1F);
		chk(poe, 40'h0000000000);
		chk(ppu, 40'h0000000000);
		$display("test reset done");
		lvl <= 40'h0000000000;
		repeat (3) @(posedge SYS_CLK_I);
		lvl <= 40'h00000000FF;
		wb(1'b0, 6'h00, 8'h00);
		chk(q, 8'h00);
		wb(1'b0, 6'h00, 8'h00);
		chk(q, 8'hFF);
		$display("test sync done");
		wb(1'b1, 6'h07, 8'hFF);
		wb(1'b1, 6'h10, 8'h81);
		wb(1'b1, 6'h11, 8'h0F);
		wb(1'b1, 6'h12, 8'h03);
		wb(1'b1, 6'h13, 8'h55);
		chk(pclaim, 40'h1BFF000881);
		chk(poe[31:24], 8'h00);
		chk(kp, 8'h81);
		wb(1'b1, 6'h10, 8'h00);
		chk(kp, 8'h00);
		$display("test claims done");
		wb(1'b1, 6'h0D, 8'hFF, 4'h0);
		wb(1'b0, 6'h0D, 8'h00);
		chk(q, 8'h00);
		chk(ppu, 40'h0000000000);
		$display("test byte select done");
		stop_test();
	end
endmodule : tb

bind parallel_port_control parallel_port_control_checker u_chk (.SYS_CLK_I(SYS_CLK_I),
	.RSTN_I(RSTN_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
	.WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
	.WB_ACK_O(WB_ACK_O), .PIN_IN_I(PIN_IN_I), .PIN_OUT_O(PIN_OUT_O), .PIN_OE_O(PIN_OE_O),
	.PIN_PULLUP_O(PIN_PULLUP_O), .PIN_CLAIM_O(PIN_CLAIM_O), .KEYPAD_INPUTS_O(KEYPAD_INPUTS_O));
